// ==== src/fcs_defs.svh ====
// constants for the flash command sequencer host controller
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// register byte offsets on the apb side
`define FCS_REG_CTRL      12'h000
`define FCS_REG_ADDR      12'h004
`define FCS_REG_WDATA     12'h008
`define FCS_REG_STATUS    12'h00C
`define FCS_REG_RDATA     12'h010

// control register fields
`define FCS_CTRL_GO_BIT   0
`define FCS_CTRL_CMD_LSB  4
`define FCS_CTRL_CMD_W    4
`define FCS_CTRL_BANK_LSB 8
`define FCS_CTRL_BANK_W   1
`define FCS_CTRL_WORD_BIT 12
`define FCS_CTRL_ACC_BIT  13
`define FCS_CTRL_HWRST_BIT 14

// status register fields
`define FCS_ST_BUSY_BIT   0
`define FCS_ST_DONE_BIT   1
`define FCS_ST_TOUT_BIT   2
`define FCS_ST_RDY_BIT    3

// command words and unlock addresses
`define FCS_UNLOCK1_ADDR  20'h00555
`define FCS_UNLOCK2_ADDR  20'h002AA
`define FCS_UNLOCK1_DATA  16'h00AA
`define FCS_UNLOCK2_DATA  16'h0055
`define FCS_RESET_DATA    16'h00F0
`define FCS_ID_DATA       16'h0090
`define FCS_PROG_DATA     16'h00A0
`define FCS_BYPASS_DATA   16'h0020
`define FCS_BYP_RST1_DATA 16'h0090
`define FCS_BYP_RST2_DATA 16'h0000
`define FCS_AUX_ENT_DATA  16'h0088
`define FCS_AUX_EX1_DATA  16'h0090
`define FCS_AUX_EX2_DATA  16'h0000

// id read offsets
`define FCS_ID_MFR_OFS    20'h00000
`define FCS_ID_DEV_W_OFS  20'h00001
`define FCS_ID_DEV_B_OFS  20'h00002
`define FCS_ID_PROT_W_OFS 8'h02
`define FCS_ID_PROT_B_OFS 8'h04

// bus timing in clock cycles at 25 MHz
`define FCS_T_SETUP_NS    40
`define FCS_T_PULSE_NS    80
`define FCS_CLK_NS        40
`define FCS_SETUP_CYC     ((`FCS_T_SETUP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_PULSE_CYC     ((`FCS_T_PULSE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`endif

// ==== src/fcs_pkg.sv ====
// types for the flash command sequencer host controller
package fcs_pkg;
  typedef enum logic [3:0] {
    FCS_OP_RESET   = 4'h0,
    FCS_OP_ID      = 4'h1,
    FCS_OP_READ    = 4'h2,
    FCS_OP_PROG    = 4'h3,
    FCS_OP_BYP_ENT = 4'h4,
    FCS_OP_BYP_PRG = 4'h5,
    FCS_OP_BYP_EX  = 4'h6,
    FCS_OP_AUX_ENT = 4'h7,
    FCS_OP_AUX_EX  = 4'h8
  } fcs_op_type;

  typedef enum logic [5:0] {
    FCS_IDLE  = 6'b000001,
    FCS_SETUP = 6'b000010,
    FCS_PULSE = 6'b000100,
    FCS_HOLD  = 6'b001000,
    FCS_WAIT  = 6'b010000,
    FCS_DONE  = 6'b100000
  } fcs_state_type;
endpackage

// ==== src/fcs_seq_rom.sv ====
// sequence table: bus cycles of each command, data out of a register
`timescale 1ns/1ns
`default_nettype none
`include "fcs_defs.svh"
module fcs_seq_rom (
  input  wire logic        clk,       // system clock
  input  wire logic        reset_n,   // async reset, low
  input  wire logic [3:0]  op,        // command code
  input  wire logic [1:0]  idx,       // cycle within the sequence
  output logic      [19:0] cyc_addr,  // address of that cycle
  output logic      [15:0] cyc_data,  // data of that cycle
  output logic      [2:0]  cyc_count  // cycles in the sequence
);
  logic [19:0] addr_d;
  logic [15:0] data_d;
  logic [2:0]  cnt_d;

  // the last cycle of program/read uses the user address; marked by 0
  always_comb begin
    addr_d = `FCS_UNLOCK1_ADDR;
    data_d = `FCS_UNLOCK1_DATA;
    cnt_d  = 3'h1;
    unique case (op)
      4'h0: begin
        data_d = `FCS_RESET_DATA;
      end
      4'h1, 4'h3, 4'h4, 4'h7: begin
        cnt_d = (op == 4'h3) ? 3'h4 : 3'h3;
        if (idx == 2'h1) begin
          addr_d = `FCS_UNLOCK2_ADDR;
          data_d = `FCS_UNLOCK2_DATA;
        end else if (idx == 2'h2) begin
          unique case (op)
            4'h1:    data_d = `FCS_ID_DATA;
            4'h3:    data_d = `FCS_PROG_DATA;
            4'h4:    data_d = `FCS_BYPASS_DATA;
            default: data_d = `FCS_AUX_ENT_DATA;
          endcase
        end else if (idx == 2'h3) begin
          addr_d = 20'h00000;
          data_d = 16'h0000;
        end
      end
      4'h2: begin
        addr_d = 20'h00000;
        data_d = 16'h0000;
      end
      4'h5: begin
        cnt_d  = 3'h2;
        data_d = (idx == 2'h0) ? `FCS_PROG_DATA : 16'h0000;
        addr_d = (idx == 2'h0) ? `FCS_UNLOCK1_ADDR : 20'h00000;
      end
      4'h6: begin
        cnt_d  = 3'h2;
        data_d = (idx == 2'h0) ? `FCS_BYP_RST1_DATA : `FCS_BYP_RST2_DATA;
      end
      4'h8: begin
        cnt_d = 3'h4;
        if (idx == 2'h1) begin
          addr_d = `FCS_UNLOCK2_ADDR;
          data_d = `FCS_UNLOCK2_DATA;
        end else if (idx == 2'h2) begin
          data_d = `FCS_AUX_EX1_DATA;
        end else if (idx == 2'h3) begin
          addr_d = 20'h00000;
          data_d = `FCS_AUX_EX2_DATA;
        end
      end
      default: begin
        data_d = `FCS_RESET_DATA;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_addr  <= 20'h00000;
      cyc_data  <= 16'h0000;
      cyc_count <= 3'h1;
    end else begin
      cyc_addr  <= addr_d;
      cyc_data  <= data_d;
      cyc_count <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// ==== src/fcs_host.sv ====
// host controller that writes command sequences into a parallel nor flash
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "fcs_defs.svh"
module fcs_host #(
  parameter int ADDR_W = 20,                  // flash address width
  parameter int DATA_W = 16                   // flash data width
) (
  input  wire logic              clk,         // 25 MHz clock
  input  wire logic              reset_n,     // async reset, low
  input  wire logic              psel,        // apb select
  input  wire logic              penable,     // apb enable
  input  wire logic              pwrite,      // apb direction
  input  wire logic [11:0]       paddr,       // apb byte address
  input  wire logic [31:0]       pwdata,      // apb write data
  output logic      [31:0]       prdata,      // apb read data
  output logic                   pready,      // apb ready
  output logic                   pslverr,     // apb error
  output logic      [ADDR_W-1:0] flash_addr,  // flash address pins
  output logic      [DATA_W-1:0] flash_dq_o,  // flash data out
  output logic                   flash_dq_oe_n, // data enable, low drives
  input  wire logic [DATA_W-1:0] flash_dq_i,  // flash data in
  output logic                   flash_ce_n,  // chip select
  output logic                   flash_we_n,  // write strobe
  output logic                   flash_oe_n,  // output enable
  output logic                   flash_word_n, // width select, low byte
  output logic                   protect_accel_pin, // accel request level
  output logic                   flash_rst_n, // hardware reset pin
  input  wire logic              ready_busy_out // flash ready, high idle
);
  fcs_pkg::fcs_state_type st_q, st_d;
  logic [15:0]       ctrl_q, ctrl_d;
  logic [ADDR_W-1:0] uaddr_q, uaddr_d;
  logic [DATA_W-1:0] uwdata_q, uwdata_d, rdata_q, rdata_d;
  logic [1:0]        idx_q, idx_d;
  logic [1:0]        tmr_q, tmr_d;
  logic              done_q, done_d, tout_q, tout_d;
  logic              rb_q, rb_d;
  logic [31:0]       prdata_d;
  logic              pready_d, pslverr_d;
  logic [ADDR_W-1:0] fa_d;
  logic [DATA_W-1:0] fdo_d;
  logic              foe_d, fce_d, fwe_d, frd_d;
  logic [19:0]       rom_addr;
  logic [15:0]       rom_data;
  logic [2:0]        rom_cnt;
  logic              wr_acc, rd_acc, go;

  fcs_seq_rom u_rom (
    .clk       (clk),
    .reset_n   (reset_n),
    .op        (ctrl_q[`FCS_CTRL_CMD_LSB +: `FCS_CTRL_CMD_W]),
    .idx       (idx_q),
    .cyc_addr  (rom_addr),
    .cyc_data  (rom_data),
    .cyc_count (rom_cnt)
  );

  // bank bit sits at the top of the flash address
  function automatic logic [ADDR_W-1:0] bank_addr(
    input logic [ADDR_W-1:0] a, input logic b);
    logic [ADDR_W-1:0] r;
    r = a;
    r[ADDR_W-1] = b;
    return r;
  endfunction

  function automatic logic is_op(input logic [15:0] c,
                                 input fcs_pkg::fcs_op_type o);
    return c[`FCS_CTRL_CMD_LSB +: `FCS_CTRL_CMD_W] == o;
  endfunction

  assign wr_acc = psel && penable && pwrite && !pready;
  assign rd_acc = psel && penable && !pwrite && !pready;
  assign go = wr_acc && paddr == `FCS_REG_CTRL &&
              pwdata[`FCS_CTRL_GO_BIT];

  //////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answers in the second enable cycle
  always_comb begin
    ctrl_d    = ctrl_q;
    uaddr_d   = uaddr_q;
    uwdata_d  = uwdata_q;
    prdata_d  = prdata;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    if (psel && penable && !pready) begin
      pready_d = 1'b1;
      unique case (paddr)
        `FCS_REG_CTRL: begin
          if (pwrite && st_q == fcs_pkg::FCS_IDLE) begin
            ctrl_d = pwdata[15:0];
          end else if (pwrite) begin
            pslverr_d = 1'b1; // busy: command refused
          end
          prdata_d = {16'h0000, ctrl_q};
        end
        `FCS_REG_ADDR: begin
          if (pwrite) begin
            uaddr_d = pwdata[ADDR_W-1:0];
          end
          prdata_d = {{(32-ADDR_W){1'b0}}, uaddr_q};
        end
        `FCS_REG_WDATA: begin
          if (pwrite) begin
            uwdata_d = pwdata[DATA_W-1:0];
          end
          prdata_d = {{(32-DATA_W){1'b0}}, uwdata_q};
        end
        `FCS_REG_STATUS: begin
          prdata_d = {28'h0000000, rb_q, tout_q, done_q,
                      st_q != fcs_pkg::FCS_IDLE};
          if (pwrite) begin
            pslverr_d = 1'b1;
          end
        end
        `FCS_REG_RDATA: begin
          prdata_d = {{(32-DATA_W){1'b0}}, rdata_q};
          if (pwrite) begin
            pslverr_d = 1'b1;
          end
        end
        default: begin
          prdata_d  = 32'h00000000;
          pslverr_d = 1'b1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // flash bus sequencer: one bus cycle per table entry
  always_comb begin
    st_d    = st_q;
    idx_d   = idx_q;
    tmr_d   = tmr_q;
    done_d  = done_q;
    tout_d  = tout_q;
    rb_d    = ready_busy_out;
    rdata_d = rdata_q;
    fa_d    = flash_addr;
    fdo_d   = flash_dq_o;
    foe_d   = flash_dq_oe_n;
    fce_d   = flash_ce_n;
    fwe_d   = flash_we_n;
    frd_d   = flash_oe_n;
    // timeout bit of the captured read word sets the sticky flag;
    // the live bus is released by now and carries nothing valid
    if (st_q == fcs_pkg::FCS_DONE && is_op(ctrl_q, fcs_pkg::FCS_OP_READ)
        && rdata_q[5]) begin
      tout_d = 1'b1;
    end
    if (go && st_q == fcs_pkg::FCS_IDLE) begin
      tout_d = 1'b0; // set above wins only in DONE, never here
    end
    unique case (st_q)
      fcs_pkg::FCS_IDLE: begin
        if (go && (pwdata[`FCS_CTRL_CMD_LSB +: `FCS_CTRL_CMD_W] ==
            4'(fcs_pkg::FCS_OP_READ) || ready_busy_out)) begin
          // commands other than read start only when ready; a go while busy is dropped
          st_d   = fcs_pkg::FCS_SETUP;
          idx_d  = 2'h0;
          done_d = 1'b0;
          // one extra cycle: the sequence table answers a clock late
          tmr_d  = 2'(`FCS_SETUP_CYC + 1);
        end
      end
      fcs_pkg::FCS_SETUP: begin
        // address out, ce low, then we low: later falling edge is we
        fce_d = 1'b0;
        if (rom_addr == 20'h00000 && rom_data == 16'h0000 &&
            !is_op(ctrl_q, fcs_pkg::FCS_OP_BYP_EX) &&
            !is_op(ctrl_q, fcs_pkg::FCS_OP_AUX_EX)) begin
          fa_d  = uaddr_q;
          fdo_d = uwdata_q;
        end else begin
          fa_d  = bank_addr(rom_addr[ADDR_W-1:0],
                    ctrl_q[`FCS_CTRL_BANK_LSB]);
          fdo_d = rom_data[DATA_W-1:0];
        end
        if (is_op(ctrl_q, fcs_pkg::FCS_OP_READ)) begin
          frd_d = 1'b0;
        end else begin
          foe_d = 1'b0;
        end
        if (tmr_q != 2'h0) begin
          tmr_d = tmr_q - 2'h1;
        end else begin
          st_d  = fcs_pkg::FCS_PULSE;
          // the count runs down to zero inclusive
          tmr_d = 2'(`FCS_PULSE_CYC - 1);
          fwe_d = is_op(ctrl_q, fcs_pkg::FCS_OP_READ);
        end
      end
      fcs_pkg::FCS_PULSE: begin
        if (tmr_q != 2'h0) begin
          tmr_d = tmr_q - 2'h1;
        end else begin
          // we rises before ce, so data is taken on the we edge
          fwe_d = 1'b1;
          st_d  = fcs_pkg::FCS_HOLD;
          if (is_op(ctrl_q, fcs_pkg::FCS_OP_READ)) begin
            rdata_d = flash_dq_i;
          end
        end
      end
      fcs_pkg::FCS_HOLD: begin
        fce_d = 1'b1;
        frd_d = 1'b1;
        foe_d = 1'b1;
        if (3'({1'b0, idx_q}) + 3'h1 >= rom_cnt) begin
          st_d = fcs_pkg::FCS_WAIT;
        end else begin
          idx_d = idx_q + 2'h1;
          st_d  = fcs_pkg::FCS_SETUP;
          tmr_d = 2'(`FCS_SETUP_CYC + 1);
        end
      end
      fcs_pkg::FCS_WAIT: begin
        // program runs inside the flash; wait on ready/busy
        if (ready_busy_out && rb_q) begin
          st_d = fcs_pkg::FCS_DONE;
        end
      end
      fcs_pkg::FCS_DONE: begin
        done_d = 1'b1;
        st_d   = fcs_pkg::FCS_IDLE;
      end
      default: begin
        st_d = fcs_pkg::FCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q          <= fcs_pkg::FCS_IDLE;
      ctrl_q        <= 16'h0000;
      uaddr_q       <= '0;
      uwdata_q      <= '0;
      rdata_q       <= '0;
      idx_q         <= 2'h0;
      tmr_q         <= 2'h0;
      done_q        <= 1'b0;
      tout_q        <= 1'b0;
      rb_q          <= 1'b0;
      prdata        <= 32'h00000000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      flash_addr    <= '0;
      flash_dq_o    <= '0;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_word_n  <= 1'b1;
      protect_accel_pin <= 1'b0;
      flash_rst_n   <= 1'b0;
    end else begin
      st_q          <= st_d;
      ctrl_q        <= ctrl_d;
      uaddr_q       <= uaddr_d;
      uwdata_q      <= uwdata_d;
      rdata_q       <= rdata_d;
      idx_q         <= idx_d;
      tmr_q         <= tmr_d;
      done_q        <= done_d;
      tout_q        <= tout_d;
      rb_q          <= rb_d;
      prdata        <= prdata_d;
      pready        <= pready_d;
      pslverr       <= pslverr_d;
      flash_addr    <= fa_d;
      flash_dq_o    <= fdo_d;
      flash_dq_oe_n <= foe_d;
      flash_ce_n    <= fce_d;
      flash_we_n    <= fwe_d;
      flash_oe_n    <= frd_d;
      flash_word_n  <= ctrl_q[`FCS_CTRL_WORD_BIT];
      protect_accel_pin <= ctrl_q[`FCS_CTRL_ACC_BIT];
      // hardware reset pin is the inverse of control bit 14, low aborts the flash
      flash_rst_n   <= !ctrl_q[`FCS_CTRL_HWRST_BIT];
    end
  end
endmodule
`default_nettype wire

// ==== verif/fcs_host_props.sv ====
// checker of apb answers and flash strobe timing of fcs_host
`timescale 1ns/1ns
`default_nettype none
module fcs_host_props #(
  parameter int ADDR_W = 20,              // flash address width
  parameter int DATA_W = 16               // flash data width
) (
  input wire logic              clk,           // clock
  input wire logic              reset_n,       // reset, low
  input wire logic              psel,          // apb select
  input wire logic              penable,       // apb enable
  input wire logic              pwrite,        // apb direction
  input wire logic [11:0]       paddr,         // apb address
  input wire logic [31:0]       prdata,        // apb read data
  input wire logic              pready,        // apb ready
  input wire logic              pslverr,       // apb error
  input wire logic [ADDR_W-1:0] flash_addr,    // flash address
  input wire logic [DATA_W-1:0] flash_dq_o,    // flash data out
  input wire logic              flash_dq_oe_n, // data enable
  input wire logic              flash_ce_n,    // chip select
  input wire logic              flash_we_n,    // write strobe
  input wire logic              flash_oe_n     // output enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  property p_wait;
    psel && penable && !pready |=> pready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_unmap;
    psel && penable && !pwrite && !pready && paddr > 12'h010
      |=> pslverr && prdata == 32'h0;
  endproperty
  property p_stwr;
    psel && penable && pwrite && !pready && paddr == 12'h00C |=> pslverr;
  endproperty
  property p_we_ce;
    !flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n;
  endproperty
  property p_setup;
    $fell(flash_we_n) |-> !$past(flash_ce_n) && !$past(flash_ce_n, 2);
  endproperty
  property p_we_len;
    $fell(flash_we_n) |-> ##1 !flash_we_n ##1 flash_we_n;
  endproperty
  property p_hold;
    !flash_we_n |=> $stable(flash_addr) && $stable(flash_dq_o);
  endproperty
  property p_oe;
    !flash_oe_n |-> flash_dq_oe_n;
  endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  a_pulse: assert property (p_pulse) else $error("pready too long");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
  a_stwr: assert property (p_stwr) else $error("status write accepted");
  a_we_ce: assert property (p_we_ce) else $error("write strobe alone");
  a_setup: assert property (p_setup) else $error("setup short");
  a_we_len: assert property (p_we_len) else $error("we pulse width");
  a_hold: assert property (p_hold) else $error("addr/data moved");
  a_oe: assert property (p_oe) else $error("dq contention");
  c_write: cover property ($fell(flash_we_n));
  c_read: cover property ($fell(flash_oe_n));
  c_err: cover property (pslverr);
endmodule
bind fcs_host fcs_host_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
  .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .flash_addr, .flash_dq_o, .flash_dq_oe_n, .flash_ce_n,
  .flash_we_n, .flash_oe_n);
`default_nettype wire

// ==== verif/fcs_flash_model.sv ====
// behavioural model of the parallel nor flash driven by fcs_host
`timescale 1ns/1ns
`default_nettype none
module fcs_flash_model #(
  parameter logic [15:0] MFR_CODE = 16'h00C5, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h2B6E, // arbitrary value
  parameter int          BUSY_NS  = 400       // internal program time
) (
  input  wire logic [19:0] flash_addr,        // address
  input  wire logic [15:0] flash_dq_o,        // data from host
  output logic      [15:0] flash_dq_i,        // data to host
  input  wire logic        flash_ce_n,        // chip select
  input  wire logic        flash_we_n,        // write strobe
  input  wire logic        flash_oe_n,        // output enable
  input  wire logic        flash_word_n,      // high: word wide
  input  wire logic        protect_accel_pin, // high voltage
  input  wire logic        flash_rst_n,       // hardware reset
  output logic             ready_busy_out     // high when idle
);
  logic [15:0] mem [0:255];
  logic [15:0] aux_mem [0:15];
  logic [19:0] a_q;
  logic [15:0] last, rd_val;
  logic [2:0]  step;
  logic [1:0]  mode; // 0 array, 1 identify, 2 fast program
  logic        aux, busy, id_bank;
  wire         wr = !flash_we_n && !flash_ce_n;
  wire         rd = !flash_oe_n && !flash_ce_n;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
    for (int i = 0; i < 16; i++) aux_mem[i] = 16'hFFFF;
    {step, mode, aux, busy, id_bank, last} = '0;
  end
  assign ready_busy_out = !busy;
  ////////////////////////////////////////
  task automatic prog(input logic [19:0] a, input logic [15:0] d);
    logic [15:0] m;
    m = flash_word_n ? d : {8'hFF, d[7:0]};
    if (aux) aux_mem[a[3:0]] &= m;
    else mem[a[7:0]] &= m;
    busy = 1'b1;
    busy <= #BUSY_NS 1'b0;
  endtask
  task automatic cmd(input logic [19:0] a, input logic [7:0] d);
    logic u1;
    u1 = a[11:0] == 12'h555;
    if (mode == 2'd2) begin
      if (step == 3'd1) prog(a, {flash_dq_o[15:8], d});
      if (step == 3'd2 && d == 8'h00) mode = 2'd0;
      if (step != 3'd0) step = 3'd0;
      else step = d == 8'hA0 ? 3'd1 : d == 8'h90 ? 3'd2 : 3'd0;
    end else if (d == 8'hF0) begin
      {mode, step} = '0;
    end else case (step)
      3'd1: step = (a[11:0] == 12'h2AA && d == 8'h55) ? 3'd2 : 3'd0;
      3'd2: begin
        step = (u1 && d == 8'hA0) ? 3'd4 : (u1 && aux && d == 8'h90);
        if (u1 && !aux && d == 8'h90) {mode, id_bank} = {2'd1, a[19]};
        if (u1 && d == 8'h20) mode = 2'd2;
        if (u1 && d == 8'h88) aux = 1'b1;
        if (step == 3'd1) step = 3'd3;
      end
      3'd3: {aux, step} = {aux && d != 8'h00, 3'd0};
      3'd4: begin
        prog(a, {flash_dq_o[15:8], d});
        step = 3'd0;
      end
      default: step = (u1 && d == 8'hAA) ? 3'd1 : 3'd0;
    endcase
  endtask
  always @(posedge wr) a_q = flash_addr;
  always @(negedge wr) if (flash_rst_n && !busy) cmd(a_q, flash_dq_o[7:0]);
  always @(negedge flash_rst_n) {step, mode, aux, busy} = '0;
  always @(posedge protect_accel_pin) mode = 2'd2;
  ////////////////////////////////////////
  always @* begin
    rd_val = aux ? aux_mem[flash_addr[3:0]] : mem[flash_addr[7:0]];
    if (mode == 2'd1 && flash_addr[19] == id_bank) begin
      if (flash_addr[7:0] == 8'h00) rd_val = MFR_CODE;
      else if (flash_addr[7:0] == (flash_word_n ? 8'h01 : 8'h02))
        rd_val = DEV_CODE;
      else if (flash_addr[7:0] == (flash_word_n ? 8'h02 : 8'h04))
        rd_val = {15'h0, flash_addr[12]};
    end
  end
  always @* if (rd) last = rd_val;
  // released bus shows the inverse, so a late sample never reads stale data
  assign flash_dq_i = rd ? rd_val : ~last;
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench: fcs_host over apb against the flash model
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] flash_addr;
  logic [15:0] flash_dq_o, flash_dq_i;
  logic        flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n;
  logic        flash_word_n, protect_accel_pin, flash_rst_n, ready_busy_out;
  int          fails, samples_checked, cyc;
  localparam logic [15:0] MFR = 16'h00C5; // arbitrary value
  localparam logic [15:0] DEV = 16'h2B6E; // arbitrary value
  localparam logic [31:0] WD  = 32'h0000_1000;
  fcs_host uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .flash_addr, .flash_dq_o, .flash_dq_oe_n,
    .flash_dq_i, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_word_n,
    .protect_accel_pin, .flash_rst_n, .ready_busy_out);
  fcs_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) fm (.flash_addr,
    .flash_dq_o, .flash_dq_i, .flash_ce_n, .flash_we_n, .flash_oe_n,
    .flash_word_n, .protect_accel_pin, .flash_rst_n, .ready_busy_out);
  always #20 clk = ~clk;
  ////////////////////////////////////////
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic go(input logic [3:0] op, input logic [19:0] a,
                    input logic [15:0] d, input logic [31:0] x);
    apb(1'b1, 12'h004, {12'h0, a});
    apb(1'b1, 12'h008, {16'h0, d});
    apb(1'b1, 12'h000, x | {23'h0, a[19], op, 4'h1});
  endtask
  task automatic wt();
    rd = '1;
    for (int i = 0; i < 100 && rd[0] !== 1'b0; i++) apb(1'b0, 12'h00C, 0);
    chk("done", 32'h1, {31'h0, rd[1]});
  endtask
  task automatic fin(input logic [3:0] op, input logic [19:0] a,
                     input logic [15:0] d, input logic [31:0] x);
    go(op, a, d, x);
    wt();
  endtask
  task automatic rdw(input logic [19:0] a, input logic [15:0] e, string nm);
    fin(4'h2, a, 16'h0, WD);
    apb(1'b0, 12'h010, 0);
    chk(nm, {16'h0, e}, rd);
  endtask
  ////////////////////////////////////////
  initial begin
    {clk, psel, penable, pwrite, paddr, pwdata} = '0;
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, 12'h00C, 0);
    chk("status", 32'h8, rd & 32'hF);
    apb(1'b0, 12'h020, 0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    apb(1'b1, 12'h00C, 32'h1);
    chk("status_wr_err", 32'h1, {31'h0, err});
    fin(4'h3, 20'h00010, 16'h1234, WD);
    apb(1'b0, 12'h004, 0);
    chk("addr_rb", 32'h10, rd);
    rdw(20'h00010, 16'h1234, "prog");
    apb(1'b0, 12'h00C, 0);
    chk("tout_set", 32'h1, {31'h0, rd[2]});
    fin(4'h3, 20'h00010, 16'h0F0F, WD);
    chk("tout_clr", 32'h0, {31'h0, rd[2]});
    rdw(20'h00010, 16'h0204, "clear_only");
    fin(4'h3, 20'h00011, 16'h0000, 32'h0);
    rdw(20'h00011, 16'hFF00, "byte");
    go(4'h3, 20'h00012, 16'h00FF, WD);
    apb(1'b1, 12'h000, WD | 32'h21);
    chk("busy_refuse", 32'h1, {31'h0, err});
    wt();
    rdw(20'h00012, 16'h00FF, "refused");
    fin(4'h1, 20'h00000, 16'h0, WD);
    rdw(20'h00000, MFR, "mfr");
    rdw(20'h00001, DEV, "dev");
    rdw(20'h01002, 16'h0001, "prot");
    rdw(20'h00002, 16'h0000, "unprot");
    rdw(20'h80010, 16'h0204, "other_bank");
    fin(4'h0, 20'h00000, 16'h0, WD);
    rdw(20'h00000, 16'hFFFF, "id_exit");
    fin(4'h4, 20'h00000, 16'h0, WD);
    fin(4'h5, 20'h00020, 16'h00C3, WD);
    fin(4'h5, 20'h00021, 16'h3C00, WD);
    fin(4'h6, 20'h00000, 16'h0, WD);
    rdw(20'h00020, 16'h00C3, "fast0");
    rdw(20'h00021, 16'h3C00, "fast1");
    fin(4'h5, 20'h00023, 16'h0000, WD);
    rdw(20'h00023, 16'hFFFF, "fast_exit");
    fin(4'h5, 20'h00024, 16'h5A5A, WD | 32'h2000);
    fin(4'h6, 20'h00000, 16'h0, WD);
    rdw(20'h00024, 16'h5A5A, "accel");
    fin(4'h7, 20'h00000, 16'h0, WD);
    fin(4'h3, 20'h00005, 16'h00AA, WD);
    rdw(20'h00005, 16'h00AA, "aux");
    fin(4'h8, 20'h00000, 16'h0, WD);
    rdw(20'h00005, 16'hFFFF, "aux_exit");
    fin(4'h7, 20'h00000, 16'h0, WD);
    apb(1'b1, 12'h000, WD | 32'h4000);
    apb(1'b1, 12'h000, WD);
    rdw(20'h00005, 16'hFFFF, "hw_reset");
    test_done();
  end
endmodule
`default_nettype wire
